// File: core/cse_exec.sv
/*
  Executor for a subset of an 8-bit core's instructions: calls, jump,
  watchdog clear, clear, complement, increment, decrement, skips and
  inclusive OR, with accumulator, zero flag and return stack push.
  Assumes instructions arrive synchronous to clk_sys_in with a
  valid/ready handshake and the upper PC latch is a steady input.
*/
`timescale 1ns/1ps
`include "cse_regs.svh"

// Summary of operation
// - Call pushes PC+1, loads 11-bit target, latch bits 6:3 on top.
// - Accumulator call pushes PC+1, PC low from accumulator, high from latch.
// - Watchdog clear zeroes counter and prescaler, sets both status bits.
// - Destination bit 0 writes the accumulator, 1 the file register.
// - Complement writes inverted file register and updates zero flag.
// - Clear register writes zero and forces zero flag set.
// - Clear accumulator writes zero and forces zero flag set.
// - Decrement writes register minus one and updates zero flag.
// - Decrement-skip leaves flags, skips next instruction on zero result.
// - Jump loads 11-bit target, latch bits 6:3 above, two cycles.
// - Increment-skip leaves flags, skips next instruction on zero result.
// - OR literal into accumulator and update zero flag.
// - Increment writes register plus one and updates zero flag.
// - OR accumulator with register into destination, update zero flag.
module cse_exec (
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire logic                   instr_valid_in,
  input  cse_pkg::cse_instr_t         instr_in,
  input  wire logic [`CSE_UPL_W-1:0]  upper_pc_latch_in,
  output logic                        instr_ready_out,
  output logic      [`CSE_PC_W-1:0]   pc_out,
  output logic      [`CSE_DATA_W-1:0] accum_out,
  output logic                        result_null_flag_out,
  output cse_pkg::cse_push_t          push_out,
  output logic                        skip_out,
  output logic      [`CSE_WDT_W-1:0]  watchdog_counter_out,
  output logic                        watchdog_expired_bit_out,
  output logic                        sleep_entered_bit_out
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic to_file(input cse_pkg::cse_instr_t i);
    to_file = i.arg[`CSE_DEST_BIT];
  endfunction

  function automatic logic [`CSE_ADDR_W-1:0] faddr(
    input cse_pkg::cse_instr_t i);
    faddr = i.arg[`CSE_FADDR_MSB:0];
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  cse_pkg::cse_state_t     state, next_state;
  cse_pkg::cse_instr_t     instr, next_instr;
  logic                    next_ready;
  logic [`CSE_PC_W-1:0]    next_pc;
  logic [`CSE_DATA_W-1:0]  next_accum;
  logic                    next_zero;
  cse_pkg::cse_push_t      next_push;
  logic                    next_skip;
  logic [`CSE_PRE_W-1:0]   prescaler, next_prescaler;
  logic [`CSE_WDT_W-1:0]   next_wdt;
  logic                    next_expired;
  logic                    next_sleep;
  logic                    mem_we;
  logic [`CSE_DATA_W-1:0]  mem_wdata;
  logic [`CSE_ADDR_W-1:0]  mem_raddr;
  logic [`CSE_DATA_W-1:0]  fval;
  logic [`CSE_DATA_W-1:0]  res;
  logic                    two_cycle;

  cse_file_mem u_mem (
    .clk_sys_in  (clk_sys_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (faddr(instr)),
    .wr_data_in  (mem_wdata),
    .rd_addr_in  (mem_raddr),
    .rd_data_out (fval)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state     = state;
    next_instr     = instr;
    next_ready     = instr_ready_out;
    next_pc        = pc_out;
    next_accum     = accum_out;
    next_zero      = result_null_flag_out;
    next_push      = '0;
    next_skip      = 1'b0;
    next_expired   = watchdog_expired_bit_out;
    next_sleep     = sleep_entered_bit_out;
    mem_we         = 1'b0;
    mem_wdata      = `CSE_RST_DATA;
    mem_raddr      = faddr(instr_in);
    res            = `CSE_RST_DATA;
    two_cycle      = 1'b0;
    next_prescaler = prescaler + `CSE_PRE_W'(1);
    next_wdt       = watchdog_counter_out;
    if (&prescaler) begin
      next_wdt = watchdog_counter_out + `CSE_WDT_W'(1);
    end
    case (state)
      cse_pkg::CSE_ST_IDLE: begin
        if (instr_valid_in) begin
          next_instr = instr_in;
          next_state = cse_pkg::CSE_ST_EXEC;
          next_ready = 1'b0;
        end
      end
      cse_pkg::CSE_ST_EXEC: begin
        next_pc = pc_out + `CSE_ONE_PC;
        case (instr.op)
          cse_pkg::CSE_OP_CALL, cse_pkg::CSE_OP_JUMP: begin
            if (instr.op == cse_pkg::CSE_OP_CALL) begin
              next_push = {1'b1, pc_out + `CSE_ONE_PC};
            end
            next_pc = {upper_pc_latch_in[`CSE_UPL_HI:`CSE_UPL_LO],
                       instr.arg};
            two_cycle = 1'b1;
          end
          cse_pkg::CSE_OP_CALLACC: begin
            next_push = {1'b1, pc_out + `CSE_ONE_PC};
            next_pc   = {upper_pc_latch_in, accum_out};
            two_cycle = 1'b1;
          end
          cse_pkg::CSE_OP_KICK: begin
            next_wdt       = '0;
            next_prescaler = '0;
            next_expired   = 1'b1;
            next_sleep     = 1'b1;
          end
          cse_pkg::CSE_OP_ZREG: begin
            mem_we    = 1'b1;
            next_zero = 1'b1;
          end
          cse_pkg::CSE_OP_ZACC: begin
            next_accum = `CSE_RST_DATA;
            next_zero  = 1'b1;
          end
          cse_pkg::CSE_OP_ORLIT: begin
            res        = accum_out | instr.arg[`CSE_LIT_MSB:0];
            next_accum = res;
            next_zero  = (res == `CSE_RST_DATA);
          end
          cse_pkg::CSE_OP_INVERT, cse_pkg::CSE_OP_DEC,
          cse_pkg::CSE_OP_INC, cse_pkg::CSE_OP_ORREG,
          cse_pkg::CSE_OP_DECSKIP, cse_pkg::CSE_OP_INCSKIP: begin
            case (instr.op)
              cse_pkg::CSE_OP_INVERT: res = ~fval;
              cse_pkg::CSE_OP_ORREG:  res = accum_out | fval;
              cse_pkg::CSE_OP_DEC, cse_pkg::CSE_OP_DECSKIP: begin
                res = fval - `CSE_ONE_DATA;
              end
              default: res = fval + `CSE_ONE_DATA;
            endcase
            if (to_file(instr)) begin
              mem_we    = 1'b1;
              mem_wdata = res;
            end else begin
              next_accum = res;
            end
            if (instr.op == cse_pkg::CSE_OP_DECSKIP ||
                instr.op == cse_pkg::CSE_OP_INCSKIP) begin
              if (res == `CSE_RST_DATA) begin
                next_pc   = pc_out + `CSE_TWO_PC;
                next_skip = 1'b1;
                two_cycle = 1'b1;
              end
            end else begin
              next_zero = (res == `CSE_RST_DATA);
            end
          end
          default: begin
          end
        endcase
        if (two_cycle) begin
          next_state = cse_pkg::CSE_ST_SECOND;
        end else begin
          next_state = cse_pkg::CSE_ST_IDLE;
          next_ready = 1'b1;
        end
      end
      cse_pkg::CSE_ST_SECOND: begin
        next_state = cse_pkg::CSE_ST_IDLE;
        next_ready = 1'b1;
      end
      default: begin
        next_state = cse_pkg::CSE_ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state                    <= cse_pkg::CSE_ST_IDLE;
      instr                    <= '0;
      instr_ready_out          <= 1'b1;
      pc_out                   <= `CSE_RST_PC;
      accum_out                <= `CSE_RST_DATA;
      result_null_flag_out     <= 1'b0;
      push_out                 <= '0;
      skip_out                 <= 1'b0;
      prescaler                <= '0;
      watchdog_counter_out     <= '0;
      watchdog_expired_bit_out <= 1'b1;
      sleep_entered_bit_out    <= 1'b1;
    end else begin
      state                    <= next_state;
      instr                    <= next_instr;
      instr_ready_out          <= next_ready;
      pc_out                   <= next_pc;
      accum_out                <= next_accum;
      result_null_flag_out     <= next_zero;
      push_out                 <= next_push;
      skip_out                 <= next_skip;
      prescaler                <= next_prescaler;
      watchdog_counter_out     <= next_wdt;
      watchdog_expired_bit_out <= next_expired;
      sleep_entered_bit_out    <= next_sleep;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic in_exec;
  assign in_exec = (state == cse_pkg::CSE_ST_EXEC);

  a_call_target: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_CALL |=>
      push_out.valid && push_out.addr == $past(pc_out) + `CSE_ONE_PC &&
      pc_out == {$past(upper_pc_latch_in[`CSE_UPL_HI:`CSE_UPL_LO]),
                 $past(instr.arg)})
    else $error("call target or push wrong");

  a_accum_call: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_CALLACC |=>
      pc_out == {$past(upper_pc_latch_in), $past(accum_out)} &&
      $stable(result_null_flag_out) && !instr_ready_out ##1 instr_ready_out)
    else $error("accumulator call wrong");

  a_kick_clear: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_KICK |=>
      watchdog_counter_out == '0 && prescaler == '0 &&
      watchdog_expired_bit_out && sleep_entered_bit_out)
    else $error("watchdog clear wrong");

  a_inc_dest: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    in_exec && instr.op == cse_pkg::CSE_OP_INC && !to_file(instr) |=>
      accum_out == `CSE_DATA_W'($past(fval) + `CSE_ONE_DATA) &&
      result_null_flag_out == (accum_out == `CSE_RST_DATA))
    else $error("increment into accumulator wrong");

  a_zero_forced: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && (instr.op == cse_pkg::CSE_OP_ZREG ||
                instr.op == cse_pkg::CSE_OP_ZACC) |=>
      result_null_flag_out && instr_ready_out)
    else $error("clear did not force zero flag");

  a_jump_two: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_JUMP |=>
      !instr_ready_out && !push_out.valid ##1 instr_ready_out)
    else $error("jump not two cycles");

  a_skip_taken: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_DECSKIP &&
      fval == `CSE_ONE_DATA |=>
      skip_out && pc_out == $past(pc_out) + `CSE_TWO_PC &&
      $stable(result_null_flag_out))
    else $error("decrement skip not taken");

  a_skip_single: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_INCSKIP &&
      !(&fval) |=> !skip_out && instr_ready_out)
    else $error("increment skip took extra cycle");

  a_or_literal: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in) in_exec && instr.op == cse_pkg::CSE_OP_ORLIT |=>
      accum_out == ($past(accum_out) | $past(instr.arg[`CSE_LIT_MSB:0])))
    else $error("or literal wrong");

endmodule

// File: core/cse_regs.svh
/*
  Named constants of the instruction subset executor: instruction
  encoding, field positions, reset values and state codes.
  Assumes inclusion by bare name from the package and the core files.
*/
`ifndef CSE_REGS_SVH
`define CSE_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CSE_PC_W         15
`define CSE_DATA_W       8
`define CSE_ADDR_W       7
`define CSE_OP_W         4
`define CSE_ARG_W        11
`define CSE_UPL_W        7
`define CSE_PRE_W        8
`define CSE_WDT_W        8

// ****************************************************************
// Field positions
// ****************************************************************
`define CSE_DEST_BIT     7
`define CSE_FADDR_MSB    6
`define CSE_LIT_MSB      7
`define CSE_UPL_HI       6
`define CSE_UPL_LO       3

// ****************************************************************
// Opcode values
// ****************************************************************
`define CSE_OPC_NOP      4'h0
`define CSE_OPC_CALL     4'h1
`define CSE_OPC_CALLACC  4'h2
`define CSE_OPC_KICK     4'h3
`define CSE_OPC_INVERT   4'h4
`define CSE_OPC_ZREG     4'h5
`define CSE_OPC_ZACC     4'h6
`define CSE_OPC_DEC      4'h7
`define CSE_OPC_DECSKIP  4'h8
`define CSE_OPC_JUMP     4'h9
`define CSE_OPC_INCSKIP  4'hA
`define CSE_OPC_ORLIT    4'hB
`define CSE_OPC_INC      4'hC
`define CSE_OPC_ORREG    4'hD

// ****************************************************************
// State codes and reset values
// ****************************************************************
`define CSE_ST_IDLE      3'h1
`define CSE_ST_EXEC      3'h2
`define CSE_ST_SECOND    3'h4
`define CSE_RST_PC       15'h0000
`define CSE_RST_DATA     8'h00
`define CSE_ONE_PC       15'h0001
`define CSE_TWO_PC       15'h0002
`define CSE_ONE_DATA     8'h01

`endif

// File: core/cse_pkg.sv
/*
  Types of the instruction subset executor: opcodes, states and the
  packed carriers for instruction words and return stack pushes.
  Assumes cse_regs.svh is on the include path.
*/
`include "cse_regs.svh"

package cse_pkg;

  typedef enum logic [`CSE_OP_W-1:0] {
    CSE_OP_NOP     = `CSE_OPC_NOP,
    CSE_OP_CALL    = `CSE_OPC_CALL,
    CSE_OP_CALLACC = `CSE_OPC_CALLACC,
    CSE_OP_KICK    = `CSE_OPC_KICK,
    CSE_OP_INVERT  = `CSE_OPC_INVERT,
    CSE_OP_ZREG    = `CSE_OPC_ZREG,
    CSE_OP_ZACC    = `CSE_OPC_ZACC,
    CSE_OP_DEC     = `CSE_OPC_DEC,
    CSE_OP_DECSKIP = `CSE_OPC_DECSKIP,
    CSE_OP_JUMP    = `CSE_OPC_JUMP,
    CSE_OP_INCSKIP = `CSE_OPC_INCSKIP,
    CSE_OP_ORLIT   = `CSE_OPC_ORLIT,
    CSE_OP_INC     = `CSE_OPC_INC,
    CSE_OP_ORREG   = `CSE_OPC_ORREG
  } cse_op_t;

  typedef enum logic [2:0] {
    CSE_ST_IDLE   = `CSE_ST_IDLE,
    CSE_ST_EXEC   = `CSE_ST_EXEC,
    CSE_ST_SECOND = `CSE_ST_SECOND
  } cse_state_t;

  typedef struct packed {
    cse_op_t                 op;
    logic [`CSE_ARG_W-1:0]   arg;
  } cse_instr_t;

  typedef struct packed {
    logic                    valid;
    logic [`CSE_PC_W-1:0]    addr;
  } cse_push_t;

endpackage

// File: core/cse_file_mem.sv
/*
  File register memory of the executor: one write port, one read
  port whose data come out of a register one cycle after the address.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "cse_regs.svh"

module cse_file_mem (
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire logic                   wr_en_in,
  input  wire logic [`CSE_ADDR_W-1:0] wr_addr_in,
  input  wire logic [`CSE_DATA_W-1:0] wr_data_in,
  input  wire logic [`CSE_ADDR_W-1:0] rd_addr_in,
  output logic      [`CSE_DATA_W-1:0] rd_data_out
);

  logic [`CSE_DATA_W-1:0] cells [0:(1<<`CSE_ADDR_W)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      cells[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= `CSE_RST_DATA;
    end else begin
      rd_data_out <= cells[rd_addr_in];
    end
  end

endmodule

// File: tb/tb_top.sv
/*
  Self-checking bench of the instruction subset executor: reset values,
  every opcode with corner cases, then seeded random instructions.
  Assumes cse_pkg and cse_exec compiled before, cse_regs.svh on path.
*/
`timescale 1ns/1ps
`include "cse_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic                   clk_sys_in;
  logic                   nrst_in;
  logic                   instr_valid_in;
  cse_pkg::cse_instr_t    instr_in;
  logic [`CSE_UPL_W-1:0]  upper_pc_latch_in;
  logic                   instr_ready_out;
  logic [`CSE_PC_W-1:0]   pc_out;
  logic [`CSE_DATA_W-1:0] accum_out;
  logic                   result_null_flag_out;
  cse_pkg::cse_push_t     push_out;
  logic                   skip_out;
  logic [`CSE_WDT_W-1:0]  watchdog_counter_out;
  logic                   watchdog_expired_bit_out;
  logic                   sleep_entered_bit_out;
  int                     errors;
  int                     total_checks;
  int                     seed;
  int                     i;
  logic [31:0]            k;
  logic [7:0]             mem [128];
  logic [14:0]            e_pc;
  logic [7:0]             e_acc;
  logic                   e_z;
  cse_pkg::cse_op_t       rop;
  logic [10:0]            rarg;

  cse_exec cse_exec_i (
    .clk_sys_in               (clk_sys_in),
    .nrst_in                  (nrst_in),
    .instr_valid_in           (instr_valid_in),
    .instr_in                 (instr_in),
    .upper_pc_latch_in        (upper_pc_latch_in),
    .instr_ready_out          (instr_ready_out),
    .pc_out                   (pc_out),
    .accum_out                (accum_out),
    .result_null_flag_out     (result_null_flag_out),
    .push_out                 (push_out),
    .skip_out                 (skip_out),
    .watchdog_counter_out     (watchdog_counter_out),
    .watchdog_expired_bit_out (watchdog_expired_bit_out),
    .sleep_entered_bit_out    (sleep_entered_bit_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // ************************************************************
  // Expectation and driving
  // ************************************************************
  function automatic logic [7:0] calc(cse_pkg::cse_op_t op,
                                      logic [7:0] a, logic [7:0] f,
                                      logic [7:0] lit);
    case (op)
      cse_pkg::CSE_OP_INVERT:  calc = ~f;
      cse_pkg::CSE_OP_DEC,
      cse_pkg::CSE_OP_DECSKIP: calc = f - 8'h01;
      cse_pkg::CSE_OP_INC,
      cse_pkg::CSE_OP_INCSKIP: calc = f + 8'h01;
      cse_pkg::CSE_OP_ORLIT:   calc = a | lit;
      cse_pkg::CSE_OP_ORREG:   calc = a | f;
      default:                 calc = 8'h00;
    endcase
  endfunction

  task automatic run(input cse_pkg::cse_op_t op, input logic [10:0] arg,
                     input logic [6:0] upl);
    logic [7:0]  r;
    logic        two;
    logic        pv;
    logic        sk;
    logic [14:0] pa;
    int          n;
    n = 0;
    while (instr_ready_out !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(instr_ready_out, 1'b1)
    instr_valid_in = 1'b1;
    instr_in.op = op;
    instr_in.arg = arg;
    upper_pc_latch_in = upl;
    r = calc(op, e_acc, mem[arg[6:0]], arg[7:0]);
    two = 1'b0;
    pv = 1'b0;
    sk = 1'b0;
    pa = e_pc + 15'h0001;
    e_pc = pa;
    case (op)
      cse_pkg::CSE_OP_CALL: begin
        pv = 1'b1;
        two = 1'b1;
        e_pc = {upl[6:3], arg};
      end
      cse_pkg::CSE_OP_CALLACC: begin
        pv = 1'b1;
        two = 1'b1;
        e_pc = {upl, e_acc};
      end
      cse_pkg::CSE_OP_JUMP: begin
        two = 1'b1;
        e_pc = {upl[6:3], arg};
      end
      cse_pkg::CSE_OP_ZREG: begin
        mem[arg[6:0]] = 8'h00;
        e_z = 1'b1;
      end
      cse_pkg::CSE_OP_ZACC: begin
        e_acc = 8'h00;
        e_z = 1'b1;
      end
      cse_pkg::CSE_OP_ORLIT: begin
        e_acc = r;
        e_z = (r == 8'h00);
      end
      cse_pkg::CSE_OP_INVERT, cse_pkg::CSE_OP_DEC, cse_pkg::CSE_OP_INC,
      cse_pkg::CSE_OP_ORREG, cse_pkg::CSE_OP_DECSKIP,
      cse_pkg::CSE_OP_INCSKIP: begin
        if (arg[7])
          mem[arg[6:0]] = r;
        else
          e_acc = r;
        if (op == cse_pkg::CSE_OP_DECSKIP || op == cse_pkg::CSE_OP_INCSKIP)
        begin
          if (r == 8'h00) begin
            sk = 1'b1;
            two = 1'b1;
            e_pc = e_pc + 15'h0001;
          end
        end else
          e_z = (r == 8'h00);
      end
      default: ;
    endcase
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    instr_valid_in = 1'b0;
    `CHK(instr_ready_out, 1'b0)
    @(negedge clk_sys_in);
    `CHK(pc_out, e_pc)
    `CHK(accum_out, e_acc)
    `CHK(result_null_flag_out, e_z)
    `CHK(push_out.valid, pv)
    if (pv) `CHK(push_out.addr, pa)
    `CHK(skip_out, sk)
    `CHK(instr_ready_out, ~two)
    if (op == cse_pkg::CSE_OP_KICK) `CHK(watchdog_counter_out, 8'h0)
    `CHK(watchdog_expired_bit_out & sleep_entered_bit_out, 1'b1)
    if (two) begin
      @(negedge clk_sys_in);
      `CHK(instr_ready_out, 1'b1)
      `CHK(push_out.valid | skip_out, 1'b0)
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    #600us;
    errors++;
    finish_test;
  end

  initial begin
    seed = 32'h27974524;
    errors = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = '0;
    upper_pc_latch_in = 7'h00;
    e_pc = 15'h0000;
    e_acc = 8'h00;
    e_z = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    `CHK({instr_ready_out, pc_out, accum_out}, 24'h800000)
    `CHK({result_null_flag_out, push_out.valid, skip_out}, 3'h0)
    `CHK({watchdog_counter_out, watchdog_expired_bit_out}, 9'h001)
    `CHK(sleep_entered_bit_out, 1'b1)
    nrst_in = 1'b1;
    for (i = 0; i < 128; i++)
      run(cse_pkg::CSE_OP_ZREG, 11'(i), 7'h00);
    run(cse_pkg::CSE_OP_KICK, 11'h000, 7'h00);
    run(cse_pkg::CSE_OP_ZACC, 11'h000, 7'h00);
    run(cse_pkg::CSE_OP_ORLIT, 11'h000, 7'h00);
    run(cse_pkg::CSE_OP_INC, 11'h085, 7'h00);
    run(cse_pkg::CSE_OP_DEC, 11'h085, 7'h00);
    run(cse_pkg::CSE_OP_DECSKIP, 11'h085, 7'h00);
    run(cse_pkg::CSE_OP_INCSKIP, 11'h085, 7'h00);
    run(cse_pkg::CSE_OP_INCSKIP, 11'h005, 7'h00);
    run(cse_pkg::CSE_OP_INC, 11'h086, 7'h00);
    run(cse_pkg::CSE_OP_DECSKIP, 11'h006, 7'h00);
    run(cse_pkg::CSE_OP_INVERT, 11'h087, 7'h00);
    run(cse_pkg::CSE_OP_INVERT, 11'h087, 7'h00);
    run(cse_pkg::CSE_OP_ORLIT, 11'h0FF, 7'h00);
    run(cse_pkg::CSE_OP_ORREG, 11'h007, 7'h00);
    run(cse_pkg::CSE_OP_CALL, 11'h7FF, 7'h7F);
    run(cse_pkg::CSE_OP_CALLACC, 11'h000, 7'h55);
    run(cse_pkg::CSE_OP_JUMP, 11'h000, 7'h7F);
    run(cse_pkg::CSE_OP_JUMP, 11'h7FF, 7'h07);
    run(cse_pkg::cse_op_t'(4'hE), 11'h000, 7'h00);
    for (i = 0; i < 400; i++) begin
      k = $random(seed);
      rop = cse_pkg::cse_op_t'(k[3:0]);
      rarg = k[14:4];
      if (rop != cse_pkg::CSE_OP_CALL && rop != cse_pkg::CSE_OP_JUMP)
        rarg[10:8] = 3'h0;
      run(rop, rarg, k[21:15]);
    end
    finish_test;
  end
endmodule
